// file: cers_pkg.sv
// Package: constants, types and register map of the exception and reset sequencer
package cers_pkg;
  localparam logic [31:0] CERS_VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] CERS_VEC_DABT = 32'h0000_0010;
  localparam logic [31:0] CERS_VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] CERS_VEC_FIQ = 32'h0000_001c;
  localparam logic [4:0] CERS_MODE_SVC = 5'h13;
  localparam logic [4:0] CERS_MODE_ABT = 5'h17;
  localparam logic [4:0] CERS_MODE_IRQ = 5'h12;
  localparam logic [4:0] CERS_MODE_FIQ = 5'h11;
  localparam int CERS_TSYNC_MAX = 3;
  localparam int CERS_TLDM = 20;
  localparam int CERS_TEXC = 3;
  localparam int CERS_TFIQ = 2;
  localparam int CERS_TSYNC_MIN = 2;
  localparam int CERS_LAT_MAX = CERS_TSYNC_MAX + CERS_TLDM + CERS_TEXC + CERS_TFIQ;
  localparam int CERS_LAT_MIN = CERS_TSYNC_MIN + CERS_TFIQ;
  localparam logic [31:0] CERS_STAT_RESET = 32'h0000_00d3;
  localparam logic [31:0] CERS_PC_STEP = 32'h0000_0004;
  // AXI4-Lite register offsets
  localparam logic [7:0] CERS_REG_CTRL = 8'h00;
  localparam logic [7:0] CERS_REG_STATUS = 8'h04;
  localparam logic [7:0] CERS_REG_FETCH = 8'h08;
  localparam logic [7:0] CERS_REG_LINK = 8'h0c;
  localparam logic [7:0] CERS_REG_SAVED = 8'h10;
  localparam logic [7:0] CERS_REG_EVENT = 8'h14;
  localparam logic [7:0] CERS_REG_MASK = 8'h18;
  localparam logic [7:0] CERS_REG_LAT = 8'h1c;
  localparam int CERS_EV_W = 4;
  localparam logic [1:0] CERS_RESP_OK = 2'h0;
  localparam logic [1:0] CERS_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CERS_RUN = 3'h0,
    CERS_DABT = 3'h1,
    CERS_FIQ = 3'h3,
    CERS_IRQ = 3'h2,
    CERS_HELD = 3'h6
  } cers_state_e;
  // Status word fields
  typedef struct packed {
    logic [23:0] flags;
    logic irq_mask;
    logic fiq_mask;
    logic t_state;
    logic [4:0] mode;
  } cers_status_s;
  // Event bits: dabt, fiq, irq, decode clash
  typedef struct packed {
    logic clash;
    logic irq;
    logic fiq;
    logic dabt;
  } cers_event_s;
endpackage

// file: cers_sync.sv
// Request synchroniser with bypass for requests already synchronous
`timescale 1ns/10ps
`default_nettype none
module cers_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request lines, active low
  input wire logic [WIDTH-1:0] req_low,
  input wire logic sync_select_input,
  output logic [WIDTH-1:0] req_out_low
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stab_r;
  logic [WIDTH-1:0] bypass_r;
  // Elaboration-time guard on the lane count
  if (WIDTH < 1) begin : g_width_check
    $error("cers_sync: WIDTH must be positive");
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '1;
      stab_r <= '1;
      bypass_r <= '1;
    end else begin
      meta_r <= req_low;
      stab_r <= meta_r;
      bypass_r <= req_low;
    end
  end
  // Asynchronous requests take the extra stage
  assign req_out_low = sync_select_input ? bypass_r : stab_r;
endmodule
`default_nettype wire

// file: cers_decode.sv
// Trap decode: undefined versus software trap of an instruction word
`timescale 1ns/10ps
`default_nettype none
module cers_decode (
  // Instruction word
  input wire logic [31:0] instr,
  input wire logic instr_valid,
  // Traps
  output logic undef_trap,
  output logic swi_trap
);
  // Disjoint encodings: bits 27:24 all ones versus 27:25 011 with bit 4 set
  assign swi_trap = instr_valid && (instr[27:24] == 4'hf);
  assign undef_trap = instr_valid && (instr[27:25] == 3'h3) && instr[4];
endmodule
`default_nettype wire

// file: cers_top.sv
// Exception arbitration and reset entry sequencer with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Undefined and software traps never both fire for one instruction.
// - Data abort plus enabled fast interrupt: abort entry, then fast entry directly.
// - Data abort outranks fast interrupt in arbitration.
// - Fast return resumes in abort mode at the fetch address saved at the data-abort boundary.
// - Worst fast latency is sync, load multiple, abort and fast entry; ends at 0x1c.
// - Terms are sync 3, load multiple 20, abort entry 3, fast entry 2.
// - Least latency is shortest sync plus fast entry: four cycles.
// - Normal interrupt latency has no fixed bound.
// - In reset, abandon the instruction and fetch incrementing word addresses.
// - On reset release copy fetch address and status to supervisor copies.
// - On release set supervisor mode, both masks, clear compressed state.
// - After release fetch from zero in the 32-bit state.
// - Serve reset, data abort, fast, normal, prefetch abort, then traps.
// - Asynchronous requests get one extra synchronising cycle.
// - With fast mask clear, sample fast request low at each instruction end.
// - Vectors: data abort 0x10, normal 0x18, fast 0x1c.
module cers_top
  import cers_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core pins
  input wire logic core_reset_low,
  input wire logic fast_irq_request_low,
  input wire logic normal_irq_request_low,
  input wire logic sync_select_input,
  // Pipeline side
  input wire logic instr_end,
  input wire logic data_abort,
  input wire logic prefetch_abort,
  input wire logic [31:0] instr,
  input wire logic fiq_return,
  output logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] current_status_word,
  output logic [31:0] supervisor_link_register,
  output logic [31:0] supervisor_saved_status,
  output logic [2:0] entry_kind,
  output logic undef_take,
  output logic swi_take,
  output logic pabt_take,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [1:0] req_low;
  logic undef_d, swi_d;
  cers_state_e state_r;
  logic [2:0] cnt_r;
  cers_status_s stat_r;
  logic [31:0] pc_r, lr_abt_r;
  logic reset_q_r, dabt_pend_r;
  logic ctrl_hold_r;
  cers_event_s ev_r, mask_r, ev_set;
  logic [7:0] lat_r, lat_cnt_r;
  logic fiq_seen_r;
  logic aw_done_r, w_done_r;
  logic [7:0] aw_r;
  logic [31:0] wd_r;

  cers_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_low({fast_irq_request_low, normal_irq_request_low}),
    .sync_select_input(sync_select_input),
    .req_out_low(req_low)
  );
  cers_decode u_dec (
    .instr(instr),
    .instr_valid(instr_end),
    .undef_trap(undef_d),
    .swi_trap(swi_d)
  );
  wire fiq_ok = !req_low[1] && !stat_r.fiq_mask;
  wire irq_ok = !req_low[0] && !stat_r.irq_mask && !ctrl_hold_r;
  wire in_reset = !core_reset_low;
  wire at_end = (state_r == CERS_RUN) && instr_end && !in_reset && !(fiq_return && dabt_pend_r);
  wire st_wr = aw_done_r && w_done_r && !s_axi_bvalid && (aw_r == CERS_REG_STATUS);
  // Arbitration and entry sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= CERS_HELD;
      cnt_r <= 3'h0;
      stat_r <= CERS_STAT_RESET;
      pc_r <= CERS_VEC_RESET;
      lr_abt_r <= 32'h0;
      supervisor_link_register <= 32'h0;
      supervisor_saved_status <= 32'h0;
      reset_q_r <= 1'b1;
      dabt_pend_r <= 1'b0;
      entry_kind <= 3'h0;
      undef_take <= 1'b0;
      swi_take <= 1'b0;
      pabt_take <= 1'b0;
      fetch_valid <= 1'b0;
    end else begin
      reset_q_r <= in_reset;
      undef_take <= 1'b0;
      swi_take <= 1'b0;
      pabt_take <= 1'b0;
      fetch_valid <= 1'b1;
      if (in_reset) begin
        // Instruction abandoned; fetch walks word addresses
        state_r <= CERS_HELD;
        pc_r <= pc_r + CERS_PC_STEP;
        entry_kind <= 3'h0;
      end else if (reset_q_r) begin
        supervisor_link_register <= pc_r;
        supervisor_saved_status <= stat_r;
        stat_r.mode <= CERS_MODE_SVC;
        stat_r.irq_mask <= 1'b1;
        stat_r.fiq_mask <= 1'b1;
        stat_r.t_state <= 1'b0;
        pc_r <= CERS_VEC_RESET;
        state_r <= CERS_RUN;
        entry_kind <= 3'h1;
      end else begin
        if (st_wr) stat_r <= wd_r; // Software may open the masks; entries below win
        case (state_r)
          CERS_RUN: begin
            if (fiq_return && dabt_pend_r) begin
              pc_r <= lr_abt_r;
              stat_r.mode <= CERS_MODE_ABT;
              dabt_pend_r <= 1'b0;
            end else if (instr_end) begin
              pc_r <= pc_r + CERS_PC_STEP;
              if (data_abort) begin
                // Abort wins; a pending fast request follows it
                state_r <= CERS_DABT;
                cnt_r <= 3'(CERS_TEXC - 1);
                lr_abt_r <= pc_r;
              end else if (fiq_ok) begin
                state_r <= CERS_FIQ;
                cnt_r <= 3'(CERS_TFIQ - 1);
              end else if (irq_ok) begin
                // Normal requests wait behind an unmasked fast one at the same boundary
                state_r <= CERS_IRQ;
                cnt_r <= 3'(CERS_TFIQ - 1);
              end else if (prefetch_abort) begin
                pabt_take <= 1'b1;
              end else begin
                undef_take <= undef_d;
                swi_take <= swi_d;
              end
            end
          end
          CERS_DABT: begin
            if (cnt_r == 3'h0) begin
              pc_r <= CERS_VEC_DABT;
              stat_r.mode <= CERS_MODE_ABT;
              stat_r.irq_mask <= 1'b1;
              stat_r.t_state <= 1'b0;
              entry_kind <= 3'h2;
              if (fiq_ok) begin
                // No handler instruction between the two entries
                dabt_pend_r <= 1'b1;
                state_r <= CERS_FIQ;
                cnt_r <= 3'(CERS_TFIQ - 1);
              end else begin
                state_r <= CERS_RUN;
              end
            end else begin
              cnt_r <= cnt_r - 3'h1;
            end
          end
          CERS_FIQ, CERS_IRQ: begin
            if (cnt_r == 3'h0) begin
              state_r <= CERS_RUN;
              stat_r.irq_mask <= 1'b1;
              stat_r.t_state <= 1'b0;
              if (state_r == CERS_FIQ) begin
                pc_r <= CERS_VEC_FIQ;
                stat_r.mode <= CERS_MODE_FIQ;
                stat_r.fiq_mask <= 1'b1;
                entry_kind <= 3'h3;
              end else begin
                pc_r <= CERS_VEC_IRQ;
                stat_r.mode <= CERS_MODE_IRQ;
                entry_kind <= 3'h4;
              end
            end else begin
              cnt_r <= cnt_r - 3'h1;
            end
          end
          default: state_r <= CERS_RUN;
        endcase
      end
    end
  end
  assign fetch_addr = pc_r;
  assign current_status_word = stat_r;
  // Measured fast latency, request seen low to vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_r <= 8'h0;
      lat_cnt_r <= 8'h0;
      fiq_seen_r <= 1'b0;
    end else if (!fast_irq_request_low && !fiq_seen_r && !stat_r.fiq_mask) begin
      fiq_seen_r <= 1'b1;
      lat_cnt_r <= 8'h1;
    end else if (fiq_seen_r) begin
      lat_cnt_r <= lat_cnt_r + 8'h1;
      if (state_r == CERS_FIQ && cnt_r == 3'h0) begin
        lat_r <= lat_cnt_r + 8'h1;
        fiq_seen_r <= 1'b0;
      end
    end
  end
  // Sticky events, set beats a read clear
  always_comb begin
    ev_set = '0;
    ev_set.dabt = (state_r == CERS_DABT) && (cnt_r == 3'h0);
    ev_set.fiq = (state_r == CERS_FIQ) && (cnt_r == 3'h0);
    ev_set.irq = (state_r == CERS_IRQ) && (cnt_r == 3'h0);
    ev_set.clash = undef_d && swi_d;
  end
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_done_r && w_done_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_r <= '0;
      irq <= 1'b0;
    end else begin
      ev_r <= ((rd_go && s_axi_araddr == CERS_REG_EVENT) ? '0 : ev_r) | ev_set;
      irq <= |(ev_r & ~mask_r);
    end
  end
  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done_r <= 1'b0;
      w_done_r <= 1'b0;
      aw_r <= 8'h0;
      wd_r <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CERS_RESP_OK;
      mask_r <= '0;
      ctrl_hold_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done_r <= 1'b1;
        aw_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done_r <= 1'b1;
        wd_r <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_done_r <= 1'b0;
        w_done_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= CERS_RESP_OK;
        case (aw_r)
          CERS_REG_CTRL: ctrl_hold_r <= wd_r[0];
          CERS_REG_MASK: mask_r <= wd_r[CERS_EV_W-1:0];
          CERS_REG_STATUS, CERS_REG_FETCH, CERS_REG_LINK,
          CERS_REG_SAVED, CERS_REG_EVENT, CERS_REG_LAT: ;
          default: s_axi_bresp <= CERS_RESP_SLVERR;
        endcase
      end
    end
  end
  assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
  assign s_axi_wready = !w_done_r && !s_axi_bvalid;
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= CERS_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= CERS_RESP_OK;
      case (s_axi_araddr)
        CERS_REG_CTRL: s_axi_rdata <= {31'h0, ctrl_hold_r};
        CERS_REG_STATUS: s_axi_rdata <= stat_r;
        CERS_REG_FETCH: s_axi_rdata <= pc_r;
        CERS_REG_LINK: s_axi_rdata <= supervisor_link_register;
        CERS_REG_SAVED: s_axi_rdata <= supervisor_saved_status;
        CERS_REG_EVENT: s_axi_rdata <= {28'h0, ev_r};
        CERS_REG_MASK: s_axi_rdata <= {28'h0, mask_r};
        CERS_REG_LAT: s_axi_rdata <= {24'h0, lat_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= CERS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  a_abort_then_fiq: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == CERS_DABT && cnt_r == 3'h0 && fiq_ok && core_reset_low && !reset_q_r)
    |=> (state_r == CERS_FIQ));
  a_abort_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (at_end && data_abort) |=> (state_r == CERS_DABT));
  a_fiq_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == CERS_FIQ && cnt_r == 3'h0 && core_reset_low && !reset_q_r)
    |=> (pc_r == CERS_VEC_FIQ && stat_r.fiq_mask));
  a_dabt_length: assert property (@(posedge aclk) disable iff (!aresetn)
    (at_end && data_abort) ##1 core_reset_low[*3] |=> (pc_r == CERS_VEC_DABT));
  a_reset_walk: assert property (@(posedge aclk) disable iff (!aresetn)
    (!core_reset_low && $past(!core_reset_low)) |=> (pc_r == $past(pc_r) + CERS_PC_STEP));
  a_reset_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (reset_q_r && core_reset_low) |=>
    (stat_r.mode == CERS_MODE_SVC && stat_r.irq_mask && stat_r.fiq_mask && !stat_r.t_state));
  a_reset_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    (reset_q_r && core_reset_low) |=> (pc_r == CERS_VEC_RESET && state_r == CERS_RUN));
  a_trap_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(undef_take && swi_take));
  a_fiq_return: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == CERS_RUN && fiq_return && dabt_pend_r && core_reset_low && !reset_q_r)
    |=> (pc_r == $past(lr_abt_r)));
endmodule
`default_nettype wire

// file: cers_pipe_model.sv
// Pipeline and memory-abort model that feeds instruction boundaries to the sequencer
`timescale 1ns/10ps
`default_nettype none
module cers_pipe_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench
  input wire logic go,
  input wire logic want_dabt,
  input wire logic want_pabt,
  input wire logic want_ret,
  input wire logic [31:0] word,
  // Pipeline side of the sequencer
  output logic instr_end,
  output logic data_abort,
  output logic prefetch_abort,
  output logic fiq_return,
  output logic [31:0] instr
);
  // Aborts only qualify the one boundary cycle, as a real memory system would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_end <= 1'b0;
      data_abort <= 1'b0;
      prefetch_abort <= 1'b0;
      fiq_return <= 1'b0;
      instr <= 32'h0000_0000;
    end else begin
      instr_end <= go;
      data_abort <= go & want_dabt;
      prefetch_abort <= go & want_pabt;
      fiq_return <= want_ret;
      // Word is stale between boundaries, so it keeps changing to expose misuse
      instr <= go ? word : ~instr;
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the exception and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cers_pkg::*;
  typedef struct packed {
    logic dabt;
    logic pabt;
    logic fiq;
    logic irq;
    logic [31:0] vec;
    logic [3:0] lat;
    logic [2:0] kind;
  } cers_row_s;
  logic aclk, aresetn, core_reset_low, fast_irq_request_low, normal_irq_request_low;
  logic sync_select_input, instr_end, data_abort, prefetch_abort, fiq_return;
  logic [31:0] instr, fetch_addr, current_status_word, supervisor_link_register;
  logic [31:0] supervisor_saved_status, word, rd, a;
  logic fetch_valid, undef_take, swi_take, pabt_take, irq, go, want_dabt, want_pabt, want_ret;
  logic [2:0] entry_kind;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors, n_tests, i;
  cers_row_s rows [5];

  cers_top cers_top_i (.aclk, .aresetn, .core_reset_low, .fast_irq_request_low,
    .normal_irq_request_low, .sync_select_input, .instr_end, .data_abort, .prefetch_abort,
    .instr, .fiq_return, .fetch_addr, .fetch_valid, .current_status_word,
    .supervisor_link_register, .supervisor_saved_status, .entry_kind, .undef_take,
    .swi_take, .pabt_take, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cers_pipe_model cers_pipe_model_i (.aclk, .aresetn, .go, .want_dabt, .want_pabt,
    .want_ret, .word, .instr_end, .data_abort, .prefetch_abort, .fiq_return, .instr);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task timed_out();
    n_errors++;
    end_of_test();
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 50) timed_out();
  endtask

  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 50) timed_out();
  endtask

  task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    axi_rd(ad, rd, resp);
    chk(nm, rd, e);
  endtask

  // Boundary is taken at the edge after this task returns
  task automatic issue(input logic d, input logic p, input logic [31:0] w);
    @(posedge aclk);
    go <= 1'b1;
    want_dabt <= d;
    want_pabt <= p;
    word <= w;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  task automatic trap(input logic [31:0] w, input logic p, input logic [2:0] exp);
    logic [2:0] seen;
    logic both;
    int k;
    seen = 3'h0;
    both = 1'b0;
    issue(1'b0, p, w);
    for (k = 0; k < 8; k++) begin
      @(posedge aclk);
      #1;
      seen = seen | {pabt_take, undef_take, swi_take};
      if (undef_take === 1'b1 && swi_take === 1'b1) both = 1'b1;
    end
    chk("trap pulses", {29'h0, seen}, {29'h0, exp});
    chk("trap overlap", {31'h0, both}, 32'h0);
  endtask

  initial begin
    aresetn = 1'b0;
    core_reset_low = 1'b1;
    fast_irq_request_low = 1'b1;
    normal_irq_request_low = 1'b1;
    sync_select_input = 1'b1;
    {go, want_dabt, want_pabt, want_ret} = 4'h0;
    word = 32'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    n_errors = 0;
    n_tests = 0;
    rows[0] = '{1'b1, 1'b0, 1'b0, 1'b0, CERS_VEC_DABT, 4'h3, 3'h2};
    rows[1] = '{1'b0, 1'b0, 1'b1, 1'b0, CERS_VEC_FIQ, 4'h2, 3'h3};
    rows[2] = '{1'b0, 1'b0, 1'b0, 1'b1, CERS_VEC_IRQ, 4'h2, 3'h4};
    rows[3] = '{1'b0, 1'b1, 1'b1, 1'b1, CERS_VEC_FIQ, 4'h2, 3'h3};
    rows[4] = '{1'b1, 1'b1, 1'b0, 1'b0, CERS_VEC_DABT, 4'h3, 3'h2};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("status reg", CERS_REG_STATUS, CERS_STAT_RESET);
    rchk("fetch reg", CERS_REG_FETCH, CERS_VEC_RESET);
    axi_rd(8'h20, rd, resp);
    chk("unmapped read resp", {30'h0, resp}, {30'h0, CERS_RESP_SLVERR});
    chk("unmapped read data", rd, 32'h0);
    axi_wr(8'h24, 32'h0000_00ff, resp);
    chk("unmapped write resp", {30'h0, resp}, {30'h0, CERS_RESP_SLVERR});
    // Core reset: fetch keeps stepping while held, then restarts at zero
    @(posedge aclk);
    core_reset_low <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    a = fetch_addr;
    @(posedge aclk);
    #1;
    chk("fetch step in reset", fetch_addr, a + CERS_PC_STEP);
    @(posedge aclk);
    core_reset_low <= 1'b1;
    i = 0;
    while (entry_kind !== 3'h1) begin
      if (i == 10) timed_out();
      @(posedge aclk);
      #1;
      i++;
    end
    chk("fetch after release", fetch_addr, CERS_VEC_RESET);
    chk("status after release", {24'h0, current_status_word[7:0]},
        {24'h0, 2'b11, 1'b0, CERS_MODE_SVC});
    chk("fetch valid", {31'h0, fetch_valid}, 32'h1);
    chk("link copy", supervisor_link_register, a + CERS_PC_STEP + CERS_PC_STEP);
    chk("saved copy", supervisor_saved_status, CERS_STAT_RESET);
    trap(32'hef00_0000, 1'b0, 3'b001);
    trap(32'he600_0010, 1'b0, 3'b010);
    trap(32'he1a0_0000, 1'b1, 3'b100);
    axi_wr(CERS_REG_MASK, 32'h0000_000f, resp);
    axi_rd(CERS_REG_EVENT, rd, resp);
    for (i = 0; i < 5; i++) begin
      axi_wr(CERS_REG_STATUS, 32'h0000_0010, resp);
      fast_irq_request_low <= ~rows[i].fiq;
      normal_irq_request_low <= ~rows[i].irq;
      repeat (4) @(posedge aclk);
      issue(rows[i].dabt, rows[i].pabt, 32'he1a0_0000);
      repeat (rows[i].lat + 1) @(posedge aclk);
      #1;
      chk("entry vector", fetch_addr, rows[i].vec);
      chk("entry kind", {29'h0, entry_kind}, {29'h0, rows[i].kind});
      @(posedge aclk);
      fast_irq_request_low <= 1'b1;
      normal_irq_request_low <= 1'b1;
    end
    // Events stay hidden behind the mask until it is opened
    chk("masked irq", {31'h0, irq}, 32'h0);
    axi_wr(CERS_REG_MASK, 32'h0000_0000, resp);
    repeat (2) @(posedge aclk);
    #1;
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    rchk("events", CERS_REG_EVENT, 32'h0000_0007);
    rchk("events cleared", CERS_REG_EVENT, 32'h0);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Shortest fast entry: request and boundary arrive together
    axi_wr(CERS_REG_STATUS, 32'h0000_0010, resp);
    go <= 1'b1;
    want_dabt <= 1'b0;
    want_pabt <= 1'b0;
    fast_irq_request_low <= 1'b0;
    @(posedge aclk);
    go <= 1'b0;
    repeat (4) @(posedge aclk);
    fast_irq_request_low <= 1'b1;
    rchk("least fast latency", CERS_REG_LAT, CERS_LAT_MIN);
    // Abort and fast request together, request taken through two sync stages
    sync_select_input <= 1'b0;
    axi_wr(CERS_REG_STATUS, 32'h0000_0010, resp);
    fast_irq_request_low <= 1'b0;
    repeat (6) @(posedge aclk);
    issue(1'b1, 1'b0, 32'he1a0_0000);
    repeat (4) @(posedge aclk);
    #1;
    chk("abort first", fetch_addr, CERS_VEC_DABT);
    repeat (2) @(posedge aclk);
    #1;
    chk("fast next", fetch_addr, CERS_VEC_FIQ);
    chk("fast kind", {29'h0, entry_kind}, 32'h3);
    @(posedge aclk);
    fast_irq_request_low <= 1'b1;
    want_ret <= 1'b1;
    @(posedge aclk);
    want_ret <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk("resume abort mode", {27'h0, current_status_word[4:0]}, {27'h0, CERS_MODE_ABT});
    end_of_test();
  end
endmodule
`default_nettype wire
